// *** ecc_pkg.sv ***
// Purpose: Shared constants for the lock-step / single-channel memory ECC block
// Assumes: 32 data symbols and 4 check symbols of 8 bits per 32-byte payload
// Notes: Device index 0..15 data pairs, 16 and 17 the two check pairs
package ecc_pkg;
  // ****************************************
  // Codeword geometry
  // ****************************************
  localparam int SYM_W = 8;
  localparam int DATA_SYMS = 32;
  localparam int CHK_SYMS = 4;
  localparam int DATA_W = DATA_SYMS * SYM_W;
  localparam int CHK_W = CHK_SYMS * SYM_W;
  localparam int CW_W = DATA_W + CHK_W;
  localparam int BEAT_W = CW_W / 2;
  localparam int NIB_W = 4;
  localparam int DEV_W = 16;
  localparam int DATA_DEVS = 16;
  localparam logic [4:0] DEV_C0 = 5'h10;
  localparam logic [4:0] DEV_C1 = 5'h11;
  localparam logic [15:0] GF_POLY = 16'h100b;
  // ****************************************
  // Single-channel lanes: 8 data bytes plus one check byte
  // ****************************************
  localparam int LANES = 4;
  localparam int LANE_DW = 64;
  localparam int LANE_CW = 8;
  // ****************************************
  // Ranks, failed-device tracking, slots
  // ****************************************
  localparam int RANKS = 8;
  localparam int RANK_W = 3;
  localparam int CNT_W = 4;
  localparam logic [3:0] BAD_THRESH = 4'h3;
  localparam int SLOTS = 4;
  localparam int SPEED_W = 3;
  // ****************************************
  // Poison pattern and latencies in cycles
  // ****************************************
  localparam logic [287:0] POISON_CW = 288'hff00ff;
  localparam int RD_LATENCY = 2;
  localparam int WR_LATENCY = 1;
endpackage : ecc_pkg

// *** secded_lane_if.sv ***
// Purpose: Carries one single-channel lane's encode and decode signals
// Assumes: Purely combinational lane behind it
// Notes: Eight data bytes plus one check byte per lane
`timescale 1ns/1ps
interface secded_lane_if;
  logic [63:0] enc_data;
  logic [7:0] enc_chk;
  logic [63:0] dec_data;
  logic [7:0] dec_chk;
  logic [63:0] cor_data;
  logic [7:0] cor_chk;
  logic ce;
  logic ue;
  modport lane (input enc_data, dec_data, dec_chk, output enc_chk, cor_data, cor_chk, ce, ue);
  modport user (output enc_data, dec_data, dec_chk, input enc_chk, cor_data, cor_chk, ce, ue);
endinterface : secded_lane_if

// *** secded_lane.sv ***
// Purpose: Single-bit-correct, double-bit-detect code over eight data bytes
// Assumes: Extended Hamming code, check byte = {overall parity, 7 Hamming bits}
// Notes: Combinational; one instance per eight-byte group
`timescale 1ns/1ps
module secded_lane (
  secded_lane_if.lane io
);
  // Column of data bit idx: the idx-th non-power-of-two from 3 upward
  function automatic logic [6:0] col(input int idx);
    int n;
    col = 7'h0;
    n = 0;
    for (int v = 3; v < 128; v++) begin
      if ((v & (v - 1)) != 0) begin
        if (n == idx) col = 7'(v);
        n++;
      end
    end
  endfunction : col

  function automatic logic [6:0] hamm(input logic [63:0] d);
    hamm = 7'h0;
    for (int i = 0; i < 64; i++) begin
      if (d[i]) hamm = hamm ^ col(i);
    end
  endfunction : hamm

  logic [6:0] enc_h;
  logic [6:0] syn;
  logic par;

  // ****************************************
  // Encode
  // ****************************************
  always_comb begin
    enc_h = hamm(io.enc_data);
    io.enc_chk = {^{io.enc_data, enc_h}, enc_h};
  end

  // ****************************************
  // Decode: odd parity means one error, even with syndrome means two
  // ****************************************
  always_comb begin
    syn = hamm(io.dec_data) ^ io.dec_chk[6:0];
    par = ^{io.dec_data, io.dec_chk};
    io.cor_data = io.dec_data;
    io.cor_chk = io.dec_chk;
    io.ce = 1'b0;
    io.ue = 1'b0;
    if (par) begin
      io.ce = 1'b1;
      if (syn == 7'h0) begin
        io.cor_chk[7] = ~io.dec_chk[7];
      end else if ((syn & (syn - 7'h1)) == 7'h0) begin
        io.cor_chk[6:0] = io.dec_chk[6:0] ^ syn;
      end else begin
        io.ce = 1'b0;
        io.ue = 1'b1;
        for (int i = 0; i < 64; i++) begin
          if (col(i) == syn) begin
            io.cor_data[i] = ~io.dec_data[i];
            io.ce = 1'b1;
            io.ue = 1'b0;
          end
        end
      end
    end else if (syn != 7'h0) begin
      io.ue = 1'b1;
    end
  end
endmodule : secded_lane

// *** lockstep_device_ecc_scrub.sv ***
// Purpose: Memory ECC encode/decode, failed-device tracking and scrub write-back
// Assumes: lockstep_mode high selects the 16-bit device code, low the four lanes
// Notes: Read latency two cycles, write latency one cycle
// Contract
// - Systematic 32 data plus 4 check symbols
// - Correct errors within two adjacent symbols
// - Each x8 DRAM maps to adjacent symbol pair
// - Upper half first sends upper nibbles first
// - Lower nibble first beat, upper second
// - Same symbol mapping for writes and reads
// - Correct any single x4 or x8 failure
// - Detect two-wire faults without miscorrecting
// - Flag two failed x4 devices as detected
// - Track repeated device failures, combine with code
// - Single-channel: correct one bit, detect two
// - Ninth byte checks eight data bytes
// - Four check bytes; mismatch declares error
// - Scrub writes corrected data back, poisons uncorrectable
// - At most one scrub outstanding
// - Per rank encoded failed device identifier
// - Weight above one off marked device is fatal
// - Run timing at slowest installed DIMM speed
`timescale 1ns/1ps
module lockstep_device_ecc_scrub (
  input wire logic clk,
  input wire logic reset,
  input wire logic lockstep_mode,
  input wire logic demand_scrub_en,
  input wire logic wr_valid,
  input wire logic [255:0] wr_data,
  input wire logic wr_upper_first,
  output logic wr_out_valid_ff,
  output logic [143:0] wr_beat0_ff,
  output logic [143:0] wr_beat1_ff,
  input wire logic rd_valid,
  input wire logic [143:0] rd_beat0,
  input wire logic [143:0] rd_beat1,
  input wire logic rd_upper_first,
  input wire logic [2:0] rd_rank,
  input wire logic rd_patrol,
  output logic rd_ready_ff,
  output logic rsp_valid_ff,
  output logic [255:0] rsp_data_ff,
  output logic rsp_ce_ff,
  output logic rsp_ue_ff,
  output logic rsp_fatal_ff,
  output logic [4:0] rsp_loc_ff,
  output logic scrub_valid_ff,
  output logic scrub_poison_ff,
  output logic [2:0] scrub_rank_ff,
  output logic [143:0] scrub_beat0_ff,
  output logic [143:0] scrub_beat1_ff,
  input wire logic scrub_done,
  input wire logic patrol_wrap,
  input wire logic [3:0] slot_present,
  input wire logic [11:0] slot_speed,
  output logic [2:0] mem_speed_ff
);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] mul_alpha(input logic [15:0] v);
    mul_alpha = v[15] ? ({v[14:0], 1'b0} ^ ecc_pkg::GF_POLY) : {v[14:0], 1'b0};
  endfunction : mul_alpha

  // Check symbols {C1, C0}: C0 = sum of devices, C1 = sum of alpha^k * device k
  function automatic logic [31:0] ls_check(input logic [255:0] d);
    logic [15:0] c0;
    logic [15:0] c1;
    c0 = 16'h0;
    c1 = 16'h0;
    for (int k = ecc_pkg::DATA_DEVS - 1; k >= 0; k--) begin
      c0 = c0 ^ d[16*k +: 16];
      c1 = mul_alpha(c1) ^ d[16*k +: 16];
    end
    ls_check = {c1, c0};
  endfunction : ls_check

  // Symbol s on lines 4s..4s+3; beat 0 carries low nibbles unless upper half leads
  function automatic logic [287:0] to_beats(input logic [287:0] cw, input logic upper);
    logic [143:0] b0;
    logic [143:0] b1;
    for (int s = 0; s < 36; s++) begin
      b0[4*s +: 4] = upper ? cw[8*s+4 +: 4] : cw[8*s +: 4];
      b1[4*s +: 4] = upper ? cw[8*s +: 4] : cw[8*s+4 +: 4];
    end
    to_beats = {b1, b0};
  endfunction : to_beats

  function automatic logic [287:0] from_beats(input logic [143:0] b0, input logic [143:0] b1, input logic upper);
    logic [287:0] cw;
    for (int s = 0; s < 36; s++) begin
      cw[8*s +: 4] = upper ? b1[4*s +: 4] : b0[4*s +: 4];
      cw[8*s+4 +: 4] = upper ? b0[4*s +: 4] : b1[4*s +: 4];
    end
    from_beats = cw;
  endfunction : from_beats

  // ****************************************
  // Single-channel lanes
  // ****************************************
  secded_lane_if lane_if[ecc_pkg::LANES]();
  logic [287:0] cw_ff;
  logic [3:0] lane_ce;
  logic [3:0] lane_ue;
  logic [31:0] lane_wchk;
  logic [287:0] lane_fix;

  for (genvar i = 0; i < ecc_pkg::LANES; i++) begin : g_lane
    secded_lane u_lane (.io(lane_if[i]));
    assign lane_if[i].enc_data = wr_data[64*i +: 64];
    assign lane_if[i].dec_data = cw_ff[64*i +: 64];
    assign lane_if[i].dec_chk = cw_ff[256 + 8*i +: 8];
    assign lane_wchk[8*i +: 8] = lane_if[i].enc_chk;
    assign lane_fix[64*i +: 64] = lane_if[i].cor_data;
    assign lane_fix[256 + 8*i +: 8] = lane_if[i].cor_chk;
    assign lane_ce[i] = lane_if[i].ce;
    assign lane_ue[i] = lane_if[i].ue;
  end

  // ****************************************
  // Write path
  // ****************************************
  logic [287:0] wr_cw;
  logic [287:0] wr_map;
  always_comb begin
    wr_cw = {lockstep_mode ? ls_check(wr_data) : lane_wchk, wr_data};
    wr_map = to_beats(wr_cw, wr_upper_first);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_out_valid_ff <= 1'b0;
      wr_beat0_ff <= '0;
      wr_beat1_ff <= '0;
    end else begin
      wr_out_valid_ff <= wr_valid;
      wr_beat0_ff <= wr_map[143:0];
      wr_beat1_ff <= wr_map[287:144];
    end
  end

  // ****************************************
  // Read stage A: gather the codeword
  // ****************************************
  logic a_valid_ff;
  logic a_upper_ff;
  logic a_patrol_ff;
  logic [2:0] a_rank_ff;
  logic rd_take;
  assign rd_take = rd_valid && rd_ready_ff;

  always_ff @(posedge clk) begin
    if (reset) begin
      a_valid_ff <= 1'b0;
      a_upper_ff <= 1'b0;
      a_patrol_ff <= 1'b0;
      a_rank_ff <= '0;
      cw_ff <= '0;
    end else begin
      a_valid_ff <= rd_take;
      if (rd_take) begin
        a_upper_ff <= rd_upper_first;
        a_patrol_ff <= rd_patrol;
        a_rank_ff <= rd_rank;
        cw_ff <= from_beats(rd_beat0, rd_beat1, rd_upper_first);
      end
    end
  end

  // ****************************************
  // Lock-step decode: one 16-bit device in error is located and fixed
  // ****************************************
  logic [31:0] syn;
  logic [15:0] walk;
  logic [15:0] pat;
  logic [4:0] ls_loc;
  logic ls_ce;
  logic ls_ue;
  logic [287:0] ls_fix;
  always_comb begin
    syn = ls_check(cw_ff[255:0]) ^ cw_ff[287:256];
    walk = syn[15:0];
    pat = 16'h0;
    ls_loc = 5'h0;
    ls_ce = 1'b0;
    ls_ue = 1'b0;
    ls_fix = cw_ff;
    if (syn[15:0] != 16'h0 && syn[31:16] == 16'h0) begin
      ls_ce = 1'b1;
      ls_loc = ecc_pkg::DEV_C0;
      pat = syn[15:0];
      ls_fix[256 +: 16] = cw_ff[256 +: 16] ^ pat;
    end else if (syn[15:0] == 16'h0 && syn[31:16] != 16'h0) begin
      ls_ce = 1'b1;
      ls_loc = ecc_pkg::DEV_C1;
      pat = syn[31:16];
      ls_fix[272 +: 16] = cw_ff[272 +: 16] ^ pat;
    end else if (syn != 32'h0) begin
      // Two-device faults give no consistent position and stay uncorrected
      ls_ue = 1'b1;
      for (int j = 0; j < ecc_pkg::DATA_DEVS; j++) begin
        if (walk == syn[31:16] && ls_ue) begin
          ls_ue = 1'b0;
          ls_ce = 1'b1;
          ls_loc = 5'(j);
          pat = syn[15:0];
          ls_fix[16*j +: 16] = cw_ff[16*j +: 16] ^ pat;
        end
        walk = mul_alpha(walk);
      end
    end
  end

  // ****************************************
  // Failed-device record per rank
  // ****************************************
  logic [4:0] fail_mark_ff [ecc_pkg::RANKS];
  logic [ecc_pkg::RANKS-1:0] mark_valid_ff;
  logic [3:0] bad_cnt_ff [ecc_pkg::RANKS];
  logic heavy;
  logic alias_ue;
  logic fin_ce;
  logic fin_ue;
  always_comb begin
    heavy = lockstep_mode && ls_ce && ($countones(pat) > 1);
    alias_ue = heavy && mark_valid_ff[a_rank_ff] && (ls_loc != fail_mark_ff[a_rank_ff]);
    fin_ce = lockstep_mode ? (ls_ce && !alias_ue) : (|lane_ce && !(|lane_ue));
    fin_ue = lockstep_mode ? (ls_ue || alias_ue) : (|lane_ue);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mark_valid_ff <= '0;
      for (int r = 0; r < ecc_pkg::RANKS; r++) begin
        fail_mark_ff[r] <= '0;
        bad_cnt_ff[r] <= '0;
      end
    end else begin
      for (int r = 0; r < ecc_pkg::RANKS; r++) begin
        if (a_valid_ff && heavy && !alias_ue && a_rank_ff == 3'(r)) begin
          if (bad_cnt_ff[r] < ecc_pkg::BAD_THRESH) begin
            bad_cnt_ff[r] <= bad_cnt_ff[r] + 4'h1;
          end
          if (bad_cnt_ff[r] + 4'h1 >= ecc_pkg::BAD_THRESH && !mark_valid_ff[r]) begin
            fail_mark_ff[r] <= ls_loc;
            mark_valid_ff[r] <= 1'b1;
          end
        end else if (patrol_wrap && bad_cnt_ff[r] != 4'h0) begin
          bad_cnt_ff[r] <= bad_cnt_ff[r] - 4'h1;
        end
      end
    end
  end

  // ****************************************
  // Response stage
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      rsp_valid_ff <= 1'b0;
      rsp_data_ff <= '0;
      rsp_ce_ff <= 1'b0;
      rsp_ue_ff <= 1'b0;
      rsp_fatal_ff <= 1'b0;
      rsp_loc_ff <= '0;
    end else begin
      rsp_valid_ff <= a_valid_ff;
      if (a_valid_ff) begin
        rsp_data_ff <= lockstep_mode ? ls_fix[255:0] : lane_fix[255:0];
        rsp_ce_ff <= fin_ce;
        rsp_ue_ff <= fin_ue;
        rsp_fatal_ff <= alias_ue;
        rsp_loc_ff <= lockstep_mode ? ls_loc : {3'h0, lane_ue[3:2] != 2'h0 || lane_ce[3:2] != 2'h0,
          lane_ue[3] | lane_ce[3] | ((lane_ue[1] | lane_ce[1]) & ~(|lane_ue[3:2]) & ~(|lane_ce[3:2]))};
      end
    end
  end

  // ****************************************
  // Scrub write-back, one outstanding
  // ****************************************
  logic busy_ff;
  logic scrub_start;
  logic nxt_busy;
  logic [287:0] scrub_map;
  always_comb begin
    scrub_start = a_valid_ff && (fin_ce || fin_ue) && (a_patrol_ff || demand_scrub_en) && !busy_ff;
    nxt_busy = scrub_start || (busy_ff && !scrub_done);
    scrub_map = to_beats(fin_ue ? ecc_pkg::POISON_CW : (lockstep_mode ? ls_fix : lane_fix), a_upper_ff);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      busy_ff <= 1'b0;
      rd_ready_ff <= 1'b0;
      scrub_valid_ff <= 1'b0;
      scrub_poison_ff <= 1'b0;
      scrub_rank_ff <= '0;
      scrub_beat0_ff <= '0;
      scrub_beat1_ff <= '0;
    end else begin
      busy_ff <= nxt_busy;
      rd_ready_ff <= !nxt_busy;
      scrub_valid_ff <= scrub_start;
      if (scrub_start) begin
        scrub_poison_ff <= fin_ue;
        scrub_rank_ff <= a_rank_ff;
        scrub_beat0_ff <= scrub_map[143:0];
        scrub_beat1_ff <= scrub_map[287:144];
      end
    end
  end

  // ****************************************
  // Timing follows the slowest installed DIMM
  // ****************************************
  logic [2:0] nxt_speed;
  always_comb begin
    nxt_speed = 3'h7;
    for (int s = 0; s < ecc_pkg::SLOTS; s++) begin
      if (slot_present[s] && slot_speed[3*s +: 3] < nxt_speed) nxt_speed = slot_speed[3*s +: 3];
    end
    if (slot_present == 4'h0) nxt_speed = 3'h0;
  end

  always_ff @(posedge clk) begin
    if (reset) mem_speed_ff <= '0;
    else mem_speed_ff <= nxt_speed;
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_scrub_issue;
    $rose(busy_ff) ##0 scrub_valid_ff;
  endsequence

  a_scrub_single: assert property (busy_ff ##1 busy_ff |-> !scrub_valid_ff)
    else $error("second scrub issued while one outstanding");
  a_ready_busy: assert property (busy_ff |-> !rd_ready_ff)
    else $error("read accepted while scrub busy");
  a_rsp_latency: assert property (rd_take |-> ##2 rsp_valid_ff)
    else $error("read response not two cycles after take");
  a_ce_ue_excl: assert property (rsp_valid_ff |-> !(rsp_ce_ff && rsp_ue_ff))
    else $error("correctable and uncorrectable both set");
  a_fatal_is_ue: assert property (rsp_fatal_ff && rsp_valid_ff |-> rsp_ue_ff && lockstep_mode)
    else $error("fatal without uncorrectable");
  a_poison_data: assert property (s_scrub_issue ##0 scrub_poison_ff |->
    {scrub_beat1_ff, scrub_beat0_ff} == to_beats(ecc_pkg::POISON_CW, a_upper_ff))
    else $error("poison pattern wrong");
  a_write_latency: assert property (wr_valid |=> wr_out_valid_ff ##1 (wr_out_valid_ff == $past(wr_valid)))
    else $error("write beats late");
  a_clean_pass: assert property (a_valid_ff && syn == 32'h0 && lockstep_mode |=>
    rsp_data_ff == $past(cw_ff[255:0]) && !rsp_ce_ff && !rsp_ue_ff)
    else $error("clean lock-step read altered");
  a_speed_min: assert property (slot_present[0] |=> mem_speed_ff <= $past(slot_speed[2:0]))
    else $error("speed above slot 0 speed");
endmodule : lockstep_device_ecc_scrub

// *** mem_side_model.sv ***
// Purpose: Memory-side model holding one stored codeword
// Assumes: Codeword kept as {beat1, beat0} exactly as the block sends it
// Notes: Scrub done pulses done_delay cycles after a scrub write
`timescale 1ns/1ps
module mem_side_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic rd_valid,
  input wire logic wr_out_valid_ff,
  input wire logic [287:0] wr_cw,
  input wire logic scrub_valid_ff,
  input wire logic [287:0] scrub_cw,
  input wire logic [287:0] err,
  input wire logic [3:0] done_delay,
  output logic [143:0] rd_beat0,
  output logic [143:0] rd_beat1,
  output logic scrub_done,
  output logic [287:0] mem_ff
);
  // ****************
  // Storage and scrub completion
  // ****************
  logic [3:0] wait_ff;
  logic busy_ff;
  // Idle bus shows the inverse, never a stale copy
  assign {rd_beat1, rd_beat0} = rd_valid ? (mem_ff ^ err) : ~mem_ff;
  assign scrub_done = busy_ff && (wait_ff == 4'h1);
  always_ff @(posedge clk) begin
    if (scrub_valid_ff) begin
      mem_ff <= scrub_cw;
    end else if (wr_out_valid_ff) begin
      mem_ff <= wr_cw;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      busy_ff <= 1'h0;
      wait_ff <= 4'h0;
    end else if (scrub_valid_ff) begin
      busy_ff <= 1'h1;
      wait_ff <= done_delay;
    end else if (busy_ff) begin
      busy_ff <= (wait_ff != 4'h1);
      wait_ff <= wait_ff - 4'h1;
    end
  end
endmodule : mem_side_model

// *** lockstep_single_device_correction_ecc_scrub_tb_top.sv ***
// Purpose: Self-checking bench for the memory ECC and scrub block
// Assumes: Inputs driven at the falling edge
// Notes: Expected beats built from the symbol map
`timescale 1ns/1ps
module lockstep_single_device_correction_ecc_scrub_tb_top;
  // ****************
  // Signals
  // ****************
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic lockstep_mode = 1'h1;
  logic demand_scrub_en = 1'h0;
  logic wr_valid = 1'h0;
  logic wr_upper_first = 1'h0;
  logic rd_valid = 1'h0;
  logic rd_upper_first = 1'h0;
  logic rd_patrol = 1'h0;
  logic patrol_wrap = 1'h0;
  logic [255:0] wr_data = '0;
  logic [255:0] wdat = '0;
  logic [2:0] rd_rank = 3'h0;
  logic [3:0] slot_present = 4'h0;
  logic [11:0] slot_speed = {3'h7, 3'h1, 3'h4, 3'h6};
  logic [287:0] err = '0;
  logic [3:0] done_delay = 4'h1;
  logic [143:0] wr_beat0_ff, wr_beat1_ff, rd_beat0, rd_beat1, scrub_beat0_ff, scrub_beat1_ff;
  logic [287:0] mem_ff;
  logic [255:0] rsp_data_ff;
  logic [4:0] rsp_loc_ff;
  logic [2:0] scrub_rank_ff, mem_speed_ff;
  logic wr_out_valid_ff, rd_ready_ff, rsp_valid_ff, rsp_ce_ff, rsp_ue_ff, rsp_fatal_ff;
  logic scrub_valid_ff, scrub_poison_ff, scrub_done;
  int failures = 0;
  int samples_checked = 0;
  localparam logic [287:0] DMSK = {16'h0, {128{1'h1}}, 16'h0, {128{1'h1}}};
  localparam logic [255:0] PAT1 = {8{32'h1f2e3d4c}};
  localparam logic [255:0] PAT2 = {8{32'h5b6a7984}};

  always #5 clk = ~clk;

  lockstep_device_ecc_scrub DUT (.clk, .reset, .lockstep_mode, .demand_scrub_en, .wr_valid, .wr_data,
    .wr_upper_first, .wr_out_valid_ff, .wr_beat0_ff, .wr_beat1_ff, .rd_valid, .rd_beat0, .rd_beat1,
    .rd_upper_first, .rd_rank, .rd_patrol, .rd_ready_ff, .rsp_valid_ff, .rsp_data_ff, .rsp_ce_ff,
    .rsp_ue_ff, .rsp_fatal_ff, .rsp_loc_ff, .scrub_valid_ff, .scrub_poison_ff, .scrub_rank_ff,
    .scrub_beat0_ff, .scrub_beat1_ff, .scrub_done, .patrol_wrap, .slot_present, .slot_speed, .mem_speed_ff);

  mem_side_model mem (.clk, .reset, .rd_valid, .wr_out_valid_ff, .wr_cw({wr_beat1_ff, wr_beat0_ff}),
    .scrub_valid_ff, .scrub_cw({scrub_beat1_ff, scrub_beat0_ff}), .err, .done_delay, .rd_beat0,
    .rd_beat1, .scrub_done, .mem_ff);

  // ****************
  // Helpers
  // ****************
  function automatic logic [287:0] map_cw(input logic [287:0] cw, input logic uf);
    for (int s = 0; s < 36; s++) begin
      map_cw[4*s+:4] = uf ? cw[8*s+4+:4] : cw[8*s+:4];
      map_cw[144+4*s+:4] = uf ? cw[8*s+:4] : cw[8*s+4+:4];
    end
  endfunction : map_cw

  function automatic logic [287:0] flip(input int b);
    flip = '0;
    flip[((b % 8) < 4 ? 0 : 144) + 4 * (b / 8) + b % 4] = 1'h1;
  endfunction : flip

  task automatic give_verdict;
    $display("Checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [287:0] exp, input logic [287:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apply_reset;
    reset = 1'h1;
    repeat (6) @(negedge clk);
    chk("rd_ready_in_reset", 1'h0, rd_ready_ff);
    reset = 1'h0;
  endtask : apply_reset

  task automatic wait_ready;
    int n;
    n = 0;
    while (rd_ready_ff !== 1'h1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    if (rd_ready_ff !== 1'h1) begin
      failures++;
      give_verdict();
    end
  endtask : wait_ready

  task automatic do_wr(input logic [255:0] d, input logic uf);
    wr_data = d;
    wr_upper_first = uf;
    wr_valid = 1'h1;
    wdat = d;
    @(negedge clk);
    wr_valid = 1'h0;
    chk("wr_out_valid", 1'h1, wr_out_valid_ff);
    chk("wr_beats", map_cw({32'h0, d}, uf) & DMSK, {wr_beat1_ff, wr_beat0_ff} & DMSK);
    @(negedge clk);
  endtask : do_wr

  task automatic rd_exp(input logic [287:0] e, input logic [2:0] rk, input logic pt, input logic ce,
                        input logic ue, input logic ft, input logic [4:0] loc);
    wait_ready();
    err = e;
    rd_rank = rk;
    rd_patrol = pt;
    rd_valid = 1'h1;
    @(negedge clk);
    rd_valid = 1'h0;
    @(negedge clk);
    chk("rsp_valid", 1'h1, rsp_valid_ff);
    chk("rsp_ce", ce, rsp_ce_ff);
    chk("rsp_ue", ue, rsp_ue_ff);
    chk("rsp_fatal", ft, rsp_fatal_ff);
    if (ce && loc != 5'h1f) chk("rsp_loc", loc, rsp_loc_ff);
    if (!ue) chk("rsp_data", wdat, rsp_data_ff);
  endtask : rd_exp

  task automatic chk_scrub(input logic v, input logic p, input logic [287:0] b);
    chk("scrub_valid", v, scrub_valid_ff);
    if (v) begin
      chk("scrub_poison", p, scrub_poison_ff);
      chk("scrub_beats", b, {scrub_beat1_ff, scrub_beat0_ff});
      chk("scrub_rank", rd_rank, scrub_rank_ff);
      chk("rd_ready_busy", 1'h0, rd_ready_ff);
    end
  endtask : chk_scrub

  // ****************
  // Scenarios
  // ****************
  task automatic t_write_map;
    do_wr(PAT1, 1'h1);
    rd_upper_first = 1'h1;
    rd_exp('0, 3'h0, 1'h0, 1'h0, 1'h0, 1'h0, 5'h0);
    rd_upper_first = 1'h0;
    do_wr(PAT2, 1'h0);
    rd_exp('0, 3'h0, 1'h0, 1'h0, 1'h0, 1'h0, 5'h0);
  endtask : t_write_map

  task automatic t_device;
    for (int k = 0; k < 18; k++) begin
      rd_exp({2{144'hff << (8 * k)}}, 3'(k % 8), 1'h0, 1'h1, 1'h0, 1'h0, 5'(k));
    end
    rd_exp({2{144'hf << 40}}, 3'h5, 1'h0, 1'h1, 1'h0, 1'h0, 5'h5);
  endtask : t_device

  task automatic t_double;
    rd_exp({2{(144'hf << 8) | (144'hf << 44)}}, 3'h6, 1'h0, 1'h0, 1'h1, 1'h0, 5'h0);
    rd_exp(flip(0) | flip(204), 3'h6, 1'h0, 1'h0, 1'h1, 1'h0, 5'h0);
    rd_exp({144'h0, 144'hff << 24}, 3'h6, 1'h0, 1'h1, 1'h0, 1'h0, 5'h3);
  endtask : t_double

  task automatic t_rank;
    for (int i = 0; i < 3; i++) rd_exp({2{144'hff << 32}}, 3'h2, 1'h0, 1'h1, 1'h0, 1'h0, 5'h4);
    rd_exp({2{144'hff << 72}}, 3'h2, 1'h0, 1'h0, 1'h1, 1'h1, 5'h0);
    rd_exp({2{144'hff << 32}}, 3'h2, 1'h0, 1'h1, 1'h0, 1'h0, 5'h4);
    rd_exp({2{144'hff << 72}}, 3'h3, 1'h0, 1'h1, 1'h0, 1'h0, 5'h9);
    for (int i = 0; i < 2; i++) rd_exp({2{144'hff << 32}}, 3'h5, 1'h0, 1'h1, 1'h0, 1'h0, 5'h4);
    patrol_wrap = 1'h1;
    @(negedge clk);
    patrol_wrap = 1'h0;
    rd_exp({2{144'hff << 32}}, 3'h5, 1'h0, 1'h1, 1'h0, 1'h0, 5'h4);
    rd_exp({2{144'hff << 72}}, 3'h5, 1'h0, 1'h1, 1'h0, 1'h0, 5'h9);
  endtask : t_rank

  task automatic t_scrub;
    demand_scrub_en = 1'h1;
    done_delay = 4'h5;
    rd_exp({2{144'hff << 48}}, 3'h0, 1'h0, 1'h1, 1'h0, 1'h0, 5'h6);
    chk_scrub(1'h1, 1'h0, mem_ff);
    rd_valid = 1'h1;
    @(negedge clk);
    rd_valid = 1'h0;
    repeat (3) begin
      @(negedge clk);
      chk("refused_rsp", 1'h0, rsp_valid_ff);
    end
    rd_exp({2{(144'hf << 8) | (144'hf << 44)}}, 3'h1, 1'h0, 1'h0, 1'h1, 1'h0, 5'h0);
    chk_scrub(1'h1, 1'h1, map_cw(ecc_pkg::POISON_CW, 1'h0));
    demand_scrub_en = 1'h0;
    done_delay = 4'h1;
    wait_ready();
    do_wr(PAT1, 1'h0);
    rd_exp(flip(77), 3'h4, 1'h1, 1'h1, 1'h0, 1'h0, 5'h4);
    chk_scrub(1'h1, 1'h0, mem_ff);
    rd_exp(flip(77), 3'h4, 1'h0, 1'h1, 1'h0, 1'h0, 5'h4);
    chk_scrub(1'h0, 1'h0, mem_ff);
  endtask : t_scrub

  task automatic t_single;
    lockstep_mode = 1'h0;
    do_wr(PAT2, 1'h0);
    for (int i = 0; i < 4; i++) begin
      rd_exp(flip(64 * i + 5 * i + 3), 3'h0, 1'h0, 1'h1, 1'h0, 1'h0, 5'(i));
      rd_exp(flip(64 * i + 2) | flip(64 * i + 41), 3'h0, 1'h0, 1'h0, 1'h1, 1'h0, 5'h0);
    end
    rd_exp(flip(273), 3'h0, 1'h0, 1'h1, 1'h0, 1'h0, 5'h2);
  endtask : t_single

  task automatic t_speed;
    logic [3:0] pres [3] = '{4'hb, 4'hf, 4'h0};
    logic [2:0] exp_speed [3] = '{3'h4, 3'h1, 3'h0};
    for (int i = 0; i < 3; i++) begin
      slot_present = pres[i];
      repeat (3) @(negedge clk);
      chk("mem_speed", exp_speed[i], mem_speed_ff);
    end
  endtask : t_speed

  initial begin
    apply_reset();
    t_write_map();
    t_device();
    apply_reset();
    t_double();
    apply_reset();
    t_rank();
    t_scrub();
    t_single();
    t_speed();
    give_verdict();
  end
endmodule : lockstep_single_device_correction_ecc_scrub_tb_top
